// ---- inc/refclk_switch_pkg.sv ----
// Package of constants for the transmit reference-clock switching handshake
// Summary of operation
// - Select low picks 148.5, high 148.35
// - Request with select change or next cycle
// - Hold request until done seen high
// - Drop request, raise transmit reset next cycle
// - Transmit clock then follows newly selected reference
// - Transmit reset active high, level sensitive
// - Transmit reset synchronous to transmit clock
// - Power-down input holds transmit PLL in reset
// - Power-down input fed from power-down output
// - Merged instances share power-down and reference source
// - Power-down one bit per PLL, one or two
// - Power-down output resets the selected PLL
// - Receiver reset active high, level sensitive
// - Receiver reset synchronous to receiver core clock
// - Select stable throughout the reconfiguration interval
// - Switch effective only after reset raised, released
package refclk_switch_pkg;
  localparam int  PLL_COUNT_SWITCH = 2;   // PLLs when switching is enabled
  localparam logic SEL_REF_PRIMARY = 1'b0; // 148.5 MHz reference
  localparam logic SEL_REF_ALT     = 1'b1; // 148.35 MHz reference
  localparam int  RECONFIG_CYCLES  = 16;  // Device-side reconfiguration duration
  localparam int  TX_RESET_CYCLES  = 4;   // Width of the transmit reset pulse
  localparam int  PD_CYCLES        = 8;   // Width of a power-down pulse
  localparam int  CNT_W            = 8;
endpackage : refclk_switch_pkg

// ---- inc/refclk_switch_if.sv ----
// Interface joining the user control end and the device end
interface refclk_switch_if #(
  parameter int PLLS = refclk_switch_pkg::PLL_COUNT_SWITCH
);
  logic            pllSelect;
  logic            reconfigRequest;
  logic            reconfigDone;
  logic            txReset;
  logic            rxReset;
  logic [PLLS-1:0] pllPowerdownIn;
  logic [PLLS-1:0] pllPowerdownOut;

  modport device (
    input  pllSelect, reconfigRequest, txReset, rxReset, pllPowerdownIn,
    output reconfigDone, pllPowerdownOut
  );
  modport host (
    output pllSelect, reconfigRequest, txReset, rxReset, pllPowerdownIn,
    input  reconfigDone, pllPowerdownOut
  );
endinterface : refclk_switch_if

// ---- src/refclk_switch_device.sv ----
// Device end: reference selection, reconfiguration answer, PLL and receiver resets
module refclk_switch_device #(
  parameter int PLLS       = refclk_switch_pkg::PLL_COUNT_SWITCH,
  parameter int RECFG_CYC  = refclk_switch_pkg::RECONFIG_CYCLES
) (
  input  wire logic            core_clk,
  input  wire logic            rstn,
  refclk_switch_if.device      link,
  input  wire logic            pdRequest,
  output logic                 activeRef,
  output logic                 pendingRef,
  output logic                 txInReset,
  output logic                 rxInReset,
  output logic [PLLS-1:0]      pllHeldReset
);
  typedef enum logic [1:0] {DEV_IDLE, DEV_BUSY, DEV_DONE} dev_state_t;

  dev_state_t                         state_r;
  logic [refclk_switch_pkg::CNT_W-1:0] cnt_r;
  logic                               pendingRef_r;
  logic                               activeRef_r;
  logic                               armed_r;
  logic                               txInReset_r;
  logic                               rxInReset_r;
  logic [PLLS-1:0]                    pdOut_r;
  logic [PLLS-1:0]                    pllHeld_r;
  logic [refclk_switch_pkg::CNT_W-1:0] pdCnt_r;

  wire logic cntDone = (cnt_r == refclk_switch_pkg::CNT_W'(RECFG_CYC - 1));
  wire logic pdDone  = (pdCnt_r == refclk_switch_pkg::CNT_W'(refclk_switch_pkg::PD_CYCLES - 1));
  // Only one PLL is reset on power-down when two exist: the one in use
  wire logic [PLLS-1:0] selMask = (PLLS > 1) ? PLLS'(1) << activeRef_r : PLLS'(1);

  // Reconfiguration handshake; done is held until the request drops
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r      <= DEV_IDLE;
      cnt_r        <= '0;
      pendingRef_r <= refclk_switch_pkg::SEL_REF_PRIMARY;
    end else begin
      case (state_r)
        DEV_IDLE: begin
          cnt_r <= '0;
          if (link.reconfigRequest) begin
            state_r      <= DEV_BUSY;
            pendingRef_r <= link.pllSelect;
          end
        end
        DEV_BUSY: begin
          cnt_r <= cnt_r + 1'b1;
          if (!link.reconfigRequest) state_r <= DEV_IDLE; // Aborted request
          else if (cntDone) state_r <= DEV_DONE;
        end
        DEV_DONE: if (!link.reconfigRequest) state_r <= DEV_IDLE;
        default: state_r <= DEV_IDLE;
      endcase
    end
  end

  assign link.reconfigDone = (state_r == DEV_DONE) && link.reconfigRequest;

  // New reference becomes active only on release of a transmit reset after done
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      armed_r     <= 1'b0;
      activeRef_r <= refclk_switch_pkg::SEL_REF_PRIMARY;
      txInReset_r <= 1'b1;
      rxInReset_r <= 1'b1;
    end else begin
      txInReset_r <= link.txReset;
      rxInReset_r <= link.rxReset;
      if (state_r == DEV_DONE) armed_r <= 1'b1;
      else if (armed_r && txInReset_r && !link.txReset) begin
        armed_r     <= 1'b0;
        activeRef_r <= pendingRef_r;
      end
    end
  end

  // Power-down pulse out on request; input holds the PLLs in reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pdOut_r   <= '0;
      pdCnt_r   <= '0;
      pllHeld_r <= '1;
    end else begin
      pllHeld_r <= link.pllPowerdownIn;
      if (pdOut_r == '0) begin
        pdCnt_r <= '0;
        if (pdRequest) pdOut_r <= selMask;
      end else begin
        pdCnt_r <= pdCnt_r + 1'b1;
        if (pdDone) pdOut_r <= '0;
      end
    end
  end

  assign link.pllPowerdownOut = pdOut_r;
  assign activeRef    = activeRef_r;
  assign pendingRef   = pendingRef_r;
  assign txInReset    = txInReset_r;
  assign rxInReset    = rxInReset_r;
  assign pllHeldReset = pllHeld_r;
endmodule : refclk_switch_device

// ---- src/refclk_switch_host.sv ----
// User control end: drives select, request, transmit and receiver resets
module refclk_switch_host #(
  parameter int PLLS    = refclk_switch_pkg::PLL_COUNT_SWITCH,
  parameter int RST_CYC = refclk_switch_pkg::TX_RESET_CYCLES
) (
  input  wire logic            core_clk,
  input  wire logic            rstn,
  refclk_switch_if.host        link,
  input  wire logic            switchStart,
  input  wire logic            switchRef,
  input  wire logic            rxResetReq,
  output logic                 busy,
  output logic                 switchDone
);
  typedef enum logic [1:0] {H_IDLE, H_WAIT, H_RESET} host_state_t;

  host_state_t                         state_r;
  logic                                sel_r;
  logic                                req_r;
  logic                                txRst_r;
  logic                                rxRst_r;
  logic                                done_r;
  logic [refclk_switch_pkg::CNT_W-1:0] cnt_r;

  // Counter steps on the first high cycle, so the full count ends the pulse
  wire logic rstEnd = (cnt_r == refclk_switch_pkg::CNT_W'(RST_CYC));

  // Select and request change together; select frozen until reset ends
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= H_IDLE;
      sel_r   <= refclk_switch_pkg::SEL_REF_PRIMARY;
      req_r   <= 1'b0;
      txRst_r <= 1'b0;
      done_r  <= 1'b0;
      cnt_r   <= '0;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        H_IDLE: if (switchStart) begin
          sel_r   <= switchRef;
          req_r   <= 1'b1;
          state_r <= H_WAIT;
        end
        H_WAIT: if (link.reconfigDone) begin
          req_r   <= 1'b0;
          state_r <= H_RESET;
          cnt_r   <= '0;
        end
        H_RESET: begin
          txRst_r <= 1'b1;
          cnt_r   <= cnt_r + 1'b1;
          if (rstEnd) begin
            txRst_r <= 1'b0;
            done_r  <= 1'b1;
            state_r <= H_IDLE;
          end
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end

  // Receiver reset registered on this clock
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) rxRst_r <= 1'b1;
    else rxRst_r <= rxResetReq;
  end

  assign link.pllSelect       = sel_r;
  assign link.reconfigRequest = req_r;
  assign link.txReset         = txRst_r;
  assign link.rxReset         = rxRst_r;
  assign link.pllPowerdownIn  = link.pllPowerdownOut;
  assign busy       = (state_r != H_IDLE);
  assign switchDone = done_r;
endmodule : refclk_switch_host

// ---- tb/refclk_switch_properties.sv ----
// Checker of the handshake between the user end and the device end
module refclk_switch_properties #(
  parameter int PLLS = refclk_switch_pkg::PLL_COUNT_SWITCH
) (
  input wire logic            core_clk,
  input wire logic            rstn,
  input wire logic            pllSelect,
  input wire logic            reconfigRequest,
  input wire logic            reconfigDone,
  input wire logic            txReset,
  input wire logic [PLLS-1:0] pllPowerdownOut
);
  // One clock domain, so clock and disable are stated once
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Done must follow a request already pending on the previous edge
  property p_doneOnlyReq; reconfigDone |-> reconfigRequest && $past(reconfigRequest); endproperty
  a_doneOnlyReq: assert property (p_doneOnlyReq) else $error("done without request");
  property p_doneHold; reconfigDone |=> reconfigDone || !reconfigRequest; endproperty
  a_doneHold: assert property (p_doneHold) else $error("done dropped before request");
  property p_reqHold; reconfigRequest && !reconfigDone |=> reconfigRequest; endproperty
  a_reqHold: assert property (p_reqHold) else $error("request dropped early");
  property p_selStable;
    reconfigRequest && $past(reconfigRequest) |-> $stable(pllSelect);
  endproperty
  a_selStable: assert property (p_selStable) else $error("select moved in switch");
  property p_dropReq; reconfigDone |=> !reconfigRequest; endproperty
  a_dropReq: assert property (p_dropReq) else $error("request kept after done");
  property p_rstNext; $fell(reconfigRequest) && $past(reconfigDone) |-> ##1 txReset; endproperty
  a_rstNext: assert property (p_rstNext) else $error("reset not raised after drop");
  property p_rstWidth; $rose(txReset) |-> txReset[*4] ##1 !txReset; endproperty
  a_rstWidth: assert property (p_rstWidth) else $error("reset pulse width wrong");
  property p_doneTime;
    $rose(reconfigRequest) |-> !reconfigDone[*8] ##[1:14] reconfigDone;
  endproperty
  a_doneTime: assert property (p_doneTime) else $error("done timing wrong");
  property p_pdPulse;
    $rose(|pllPowerdownOut) |-> $onehot(pllPowerdownOut)[*8] ##1 !(|pllPowerdownOut);
  endproperty
  a_pdPulse: assert property (p_pdPulse) else $error("power-down pulse wrong");
  // Main scenarios reached
  c_done: cover property (reconfigDone);
  c_rst: cover property ($rose(txReset));
  c_pd: cover property ($rose(|pllPowerdownOut));
endmodule : refclk_switch_properties

// ---- tb/test_tx_refclk_switch_handshake.sv ----
// Testbench joining both ends of the reference-clock switch handshake
module test_tx_refclk_switch_handshake;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk, rstn, switchStart, switchRef, rxResetReq, pdRequest;
  logic       activeRef, pendingRef, txInReset, rxInReset, busy, switchDone;
  logic [1:0] pllHeldReset;
  int         errCount, checks;
  refclk_switch_if lnk ();
  refclk_switch_device i_refclk_switch_device (.core_clk, .rstn, .link(lnk), .pdRequest,
    .activeRef, .pendingRef, .txInReset, .rxInReset, .pllHeldReset);
  refclk_switch_host i_refclk_switch_host (.core_clk, .rstn, .link(lnk), .switchStart,
    .switchRef, .rxResetReq, .busy, .switchDone);
  refclk_switch_properties i_props (.core_clk, .rstn, .pllSelect(lnk.pllSelect),
    .reconfigRequest(lnk.reconfigRequest), .reconfigDone(lnk.reconfigDone),
    .txReset(lnk.txReset), .pllPowerdownOut(lnk.pllPowerdownOut));
  task automatic chk(input string nm, input logic [1:0] exp, input logic [1:0] got);
    checks++;
    if (got !== exp) begin
      errCount++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk) #1;
  endtask : tick
  task automatic giveVerdict;
    $display("Counts: %0d checks, %0d mismatches", checks, errCount);
    if (errCount == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : giveVerdict
  // A second start with the other target arrives while busy and must be ignored
  task automatic t_switch(input logic r);
    logic old;
    int   n;
    old = ~r;
    switchRef = r;
    switchStart = 1'h1;
    tick(1);
    chk("busy", 2'h1, busy);
    switchRef = ~r;
    tick(3);
    chk("pendingRef", r, pendingRef);
    switchStart = 1'h0;
    for (n = 0; n < 100 && switchDone !== 1'h1; n++) begin
      if (lnk.reconfigDone === 1'h1) chk("activeRef early", old, activeRef);
      tick(1);
    end
    chk("switchDone", 2'h1, switchDone);
    chk("txInReset", 2'h1, txInReset);
    chk("pllSelect", r, lnk.pllSelect);
    tick(3);
    chk("activeRef", r, activeRef);
    chk("busy idle", 2'h0, busy);
    chk("txInReset idle", 2'h0, txInReset);
    $display("switch test ended");
  endtask : t_switch
  task automatic t_rx;
    rxResetReq = 1'h1;
    tick(3);
    chk("rxInReset high", 2'h1, rxInReset);
    rxResetReq = 1'h0;
    tick(3);
    chk("rxInReset low", 2'h0, rxInReset);
    $display("receiver reset test ended");
  endtask : t_rx
  // Power-down must hit only the PLL now in use
  task automatic t_pd(input logic r);
    logic [1:0] exp;
    exp = r ? 2'h2 : 2'h1;
    pdRequest = 1'h1;
    tick(1);
    pdRequest = 1'h0;
    tick(2);
    chk("pllHeldReset", exp, pllHeldReset);
    tick(12);
    chk("pllHeldReset idle", 2'h0, pllHeldReset);
    $display("power-down test ended");
  endtask : t_pd
  // Clock
  initial begin
    core_clk = 1'h0;
    forever #2 core_clk = ~core_clk;
  end
  // Watchdog, well beyond the roughly 110 cycles the tests need
  initial begin
    #20000;
    errCount++;
    giveVerdict();
  end
  // Main sequence
  initial begin
    {rstn, switchStart, switchRef, rxResetReq, pdRequest} = 5'h0;
    tick(20);
    chk("txInReset in reset", 2'h1, txInReset);
    chk("pllHeldReset in reset", 2'h3, pllHeldReset);
    chk("activeRef in reset", 2'h0, activeRef);
    rstn = 1'h1;
    tick(1);
    t_switch(1'h1);
    t_pd(1'h1);
    t_switch(1'h0);
    t_pd(1'h0);
    t_rx();
    giveVerdict();
  end
endmodule : test_tx_refclk_switch_handshake
